// ===== dcfb_top.sv
/*
  Bus-matching queue: 36-bit port a writes, port b reads at 36/18/9 bits,
  two mailboxes, parity check and generation, programmable flags.
  Assumes both port clocks are pins sampled by CORE_CLK, which must run
  at least four times faster than either port clock.
*/
`timescale 1ns/1ns
// Function
// R1 - 64 by 36 word first-in first-out queue
// R2 - transfers only on enabled port clock rise
// R3 - port b long, word or byte reads
// R4 - endian low uses upper lanes
// R5 - three byte-order swap modes, any width
// R6 - swap and sizing on port b edge
// R7 - two 36-bit mailboxes bypass queue
// R8 - each mailbox has a new-mail flag
// R9 - passive parity check on each port
// R10 - optional parity generation on reads
// R11 - full flags two-stage on port a
// R12 - empty flags two-stage on port b
// R13 - almost-empty low when count within offset
// R14 - almost-full low when space within offset
// R15 - port a acts only when selected
// R16 - port a bus released when deselected
// R17 - port a bidirectional 36-bit bus
// R18 - full low in reset, high second edge
// R19 - empty low in reset, reads blocked
// R20 - reset release latches offset preset
// R21 - mail-to-b flag set, blocks, clears
// R22 - narrow reads deliver word in parts
// R23 - gray-coded pointers cross the ports
module dcfb_top #(
  parameter int DEPTH = dcfb_pkg::FIFO_DEPTH
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        PORT_A_CLOCK,
  input  wire logic        PORT_A_SELECT_N,
  input  wire logic        PORT_A_GO,
  input  wire logic        PORT_A_WRITE,
  input  wire logic        PORT_A_MAILBOX,
  input  wire logic        PORT_A_PARITY_GEN,
  input  wire logic [35:0] PORT_A_BUS_IN,
  output logic      [35:0] PORT_A_BUS_OUT,
  output logic             PORT_A_BUS_OE_N,
  input  wire logic        PORT_B_CLOCK,
  input  wire logic        PORT_B_SELECT_N,
  input  wire logic        PORT_B_GO,
  input  wire logic        PORT_B_WRITE,
  input  wire logic [1:0]  PORT_B_SIZE,
  input  wire logic [1:0]  PORT_B_SWAP,
  input  wire logic        PORT_B_PARITY_GEN,
  input  wire logic        ENDIAN_SELECT,
  input  wire logic [35:0] PORT_B_BUS_IN,
  output logic      [35:0] PORT_B_BUS_OUT,
  output logic             PORT_B_BUS_OE_N,
  input  wire logic        ODD_PARITY,
  input  wire logic [1:0]  OFFSET_PRESET_SEL,
  output logic             FULL_FLAG_N,
  output logic             ALMOST_FULL_N,
  output logic             EMPTY_FLAG_N,
  output logic             ALMOST_EMPTY_N,
  output logic             MAIL_TO_B_FLAG_N,
  output logic             MAIL_TO_A_FLAG_N,
  output logic             PARITY_ERR_A_N,
  output logic             PARITY_ERR_B_N
);
  localparam int PW = $clog2(DEPTH) + 1;   // pointer width with wrap bit
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  // offsets are seven bits wide, so the queue may not exceed that range
  if (DEPTH < 8 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two from 8 to 64");
  end

  dcfb_pkg::dcfb_a_pins_t a_s;        // synchronised port a pins
  dcfb_pkg::dcfb_b_pins_t b_s;        // synchronised port b pins
  dcfb_pkg::dcfb_misc_t   m_s;        // synchronised static pins
  dcfb_pkg::dcfb_word_t   mem [DEPTH];  // queue storage

  // every pin but RESET passes two flops; no reset here, since a cleared stage would
  // read as a selected port and a read, driving the bus during reset
  dcfb_sync #(.W($bits(dcfb_pkg::dcfb_a_pins_t))) u_sync_a (
    .clk   (CORE_CLK),
    .reset (1'b0),
    .d     ({PORT_A_CLOCK, PORT_A_SELECT_N, PORT_A_GO, PORT_A_WRITE,
             PORT_A_MAILBOX, PORT_A_PARITY_GEN, PORT_A_BUS_IN}),
    .q     (a_s)
  );
  dcfb_sync #(.W($bits(dcfb_pkg::dcfb_b_pins_t))) u_sync_b (
    .clk   (CORE_CLK),
    .reset (1'b0),
    .d     ({PORT_B_CLOCK, PORT_B_SELECT_N, PORT_B_GO, PORT_B_WRITE,
             PORT_B_SIZE, PORT_B_SWAP, PORT_B_PARITY_GEN, ENDIAN_SELECT,
             PORT_B_BUS_IN}),
    .q     (b_s)
  );
  dcfb_sync #(.W($bits(dcfb_pkg::dcfb_misc_t))) u_sync_m (
    .clk   (CORE_CLK),
    .reset (1'b0),                      // preset must be seen during reset
    .d     ({ODD_PARITY, OFFSET_PRESET_SEL}),
    .q     (m_s)
  );

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : g2b

  // state: port a side
  logic          a_clk_d, armed1, armed2;      // edge detect, reset arm
  logic [PW-1:0] wptr, w_gray, rg_a1, rg_a2;   // write ptr, read gray sync
  // state: port b side
  logic          b_clk_d;
  logic [PW-1:0] rptr, fptr, r_gray, wg_b1, wg_b2;
  logic [1:0]    part;                         // part of word on port b
  dcfb_pkg::dcfb_word_t buf_q [2];             // two-entry output buffer
  logic          buf_wp, buf_rp;
  logic [1:0]    buf_cnt;
  // state: shared
  logic [6:0]    offset;                       // latched flag offset
  dcfb_pkg::dcfb_word_t mail1, mail2, a_out, b_out;
  logic          mail_b_n, mail_a_n, pef_a_n, pef_b_n;

  // next values
  logic          next_a_clk_d, next_armed1, next_armed2, next_b_clk_d;
  logic [PW-1:0] next_wptr, next_w_gray, next_rg_a1, next_rg_a2;
  logic [PW-1:0] next_rptr, next_fptr, next_r_gray, next_wg_b1, next_wg_b2;
  logic [1:0]    next_part, next_buf_cnt;
  logic          next_buf_wp, next_buf_rp;
  logic [6:0]    next_offset;
  dcfb_pkg::dcfb_word_t next_mail1, next_mail2, next_a_out, next_b_out;
  logic          next_mail_b_n, next_mail_a_n, next_pef_a_n, next_pef_b_n;

  // decoded strobes and views
  logic          a_edge, b_edge, a_acc, b_acc;
  logic          wr_fifo, wr_mail1, rd_mail2, rd_fifo, rd_mail1, wr_mail2;
  logic          last, push, pop, buf_valid;
  logic [PW-1:0] cnt_a, cnt_b;
  logic [3:0]    lane_ok;                      // lanes in use on port b
  dcfb_pkg::dcfb_word_t sw, part_word;

  assign a_edge = a_s.clk & ~a_clk_d;
  assign b_edge = b_s.clk & ~b_clk_d;
  assign a_acc  = a_edge & ~a_s.sel_n & a_s.go;                // R2 R15
  assign b_acc  = b_edge & ~b_s.sel_n & b_s.go;                // R2

  // flags from second-stage gray pointers only
  assign cnt_a = wptr - g2b(rg_a2);                            // R23
  assign cnt_b = g2b(wg_b2) - rptr;                            // R23
  assign FULL_FLAG_N    = armed2 & (cnt_a != DEPTH_P);         // R11 R18
  // compare at offset width so large presets are not cut on small queues
  assign ALMOST_FULL_N  = 7'(DEPTH_P - cnt_a) > offset;        // R14
  assign EMPTY_FLAG_N   = cnt_b != '0;                         // R12 R19
  assign ALMOST_EMPTY_N = 7'(cnt_b) > offset;                  // R13

  assign wr_fifo  = a_acc & a_s.write & ~a_s.mbx & FULL_FLAG_N; // R18
  assign wr_mail1 = a_acc & a_s.write & a_s.mbx & mail_b_n;     // R21
  assign rd_mail2 = a_acc & ~a_s.write & a_s.mbx;
  assign rd_mail1 = b_acc & ~b_s.write & (b_s.size == dcfb_pkg::SIZE_MAIL);
  assign wr_mail2 = b_acc & b_s.write & mail_a_n;
  assign buf_valid = buf_cnt != 2'h0;
  assign rd_fifo  = b_acc & ~b_s.write & ~rd_mail1 & EMPTY_FLAG_N
                  & buf_valid;                                  // R19
  assign last = (b_s.size == dcfb_pkg::SIZE_LONG)
              | (b_s.size == dcfb_pkg::SIZE_WORD
                 && part == dcfb_pkg::PART_LAST_WORD)
              | (part == dcfb_pkg::PART_LAST_BYTE);             // R22
  assign pop  = rd_fifo & last;                                 // R22
  // fetch ahead while the buffer has room; a stall just holds fptr
  assign push = (fptr != g2b(wg_b2)) & (buf_cnt != 2'h2);

  // port a bus drivers released unless selected for a read
  assign PORT_A_BUS_OE_N = a_s.sel_n | a_s.write;              // R16 R17
  assign PORT_B_BUS_OE_N = b_s.sel_n | b_s.write;
  assign PORT_A_BUS_OUT  = a_out;
  assign PORT_B_BUS_OUT  = b_out;
  assign MAIL_TO_B_FLAG_N = mail_b_n;
  assign MAIL_TO_A_FLAG_N = mail_a_n;
  assign PARITY_ERR_A_N   = pef_a_n;
  assign PARITY_ERR_B_N   = pef_b_n;

  // pick the part of the swapped head word and place it on its lanes
  always_comb begin
    sw = dcfb_pkg::swap(buf_q[buf_rp], b_s.swap);               // R5 R6
    part_word = '0;
    lane_ok   = 4'hF;
    case (b_s.size)
      dcfb_pkg::SIZE_WORD: begin                               // R3 R4
        if (!b_s.endian) begin
          part_word[35:18] = part[0] ? sw[17:0] : sw[35:18];
          lane_ok = 4'hC;
        end else begin
          part_word[17:0] = part[0] ? sw[35:18] : sw[17:0];
          lane_ok = 4'h3;
        end
      end
      dcfb_pkg::SIZE_BYTE: begin                               // R3 R4
        if (!b_s.endian) begin
          part_word[35:27] = sw[(3 - part) * dcfb_pkg::LANE_W +: 9];
          lane_ok = 4'h8;
        end else begin
          part_word[8:0] = sw[part * dcfb_pkg::LANE_W +: 9];
          lane_ok = 4'h1;
        end
      end
      default: part_word = sw;                                 // long word
    endcase
  end

  // next values for both ports, mailboxes and parity flags
  always_comb begin
    next_a_clk_d = a_s.clk;
    next_b_clk_d = b_s.clk;
    next_armed1  = armed1 | a_edge;
    next_armed2  = armed2 | (armed1 & a_edge);                 // R18
    next_wptr    = wptr + PW'(wr_fifo);                        // R1
    next_w_gray  = next_wptr ^ (next_wptr >> 1);               // R23
    next_rg_a1   = a_edge ? r_gray : rg_a1;                    // R11
    next_rg_a2   = a_edge ? rg_a1 : rg_a2;                     // R11
    next_rptr    = rptr + PW'(pop);                            // R1
    next_r_gray  = next_rptr ^ (next_rptr >> 1);               // R23
    next_wg_b1   = b_edge ? w_gray : wg_b1;                    // R12
    next_wg_b2   = b_edge ? wg_b1 : wg_b2;                     // R12
    next_fptr    = fptr + PW'(push);
    next_buf_wp  = buf_wp ^ push;
    next_buf_rp  = buf_rp ^ pop;
    next_buf_cnt = buf_cnt + 2'(push) - 2'(pop);
    next_part    = rd_fifo ? (last ? 2'h0 : part + 2'h1) : part; // R22
    next_offset  = offset;
    if (RESET) begin                                           // R20
      case (m_s.preset)
        2'h0:    next_offset = dcfb_pkg::OFFSET_P0;
        2'h1:    next_offset = dcfb_pkg::OFFSET_P1;
        2'h2:    next_offset = dcfb_pkg::OFFSET_P2;
        default: next_offset = dcfb_pkg::OFFSET_P3;
      endcase
    end
    // mailboxes: set wins over clear as the write needs a clear flag
    next_mail1    = wr_mail1 ? a_s.bus : mail1;                // R7
    next_mail2    = wr_mail2 ? b_s.bus : mail2;                // R7
    next_mail_b_n = wr_mail1 ? 1'b0 : (rd_mail1 ? 1'b1 : mail_b_n); // R8 R21
    next_mail_a_n = wr_mail2 ? 1'b0 : (rd_mail2 ? 1'b1 : mail_a_n); // R8
    // port a read data; queue is one way so only mail can be read
    next_a_out = a_out;
    if (a_acc && !a_s.write) begin
      next_a_out = a_s.mbx ? mail2 : '0;
      if (a_s.pgen) next_a_out = dcfb_pkg::par_gen(next_a_out, m_s.odd); // R10
    end
    // port b read data is updated only on its clock edge
    next_b_out = b_out;
    if (rd_mail1 || rd_fifo) begin                             // R6
      next_b_out = rd_mail1 ? mail1 : part_word;
      if (b_s.pgen) next_b_out = dcfb_pkg::par_gen(next_b_out, m_s.odd); // R10
    end
    // passive check; data is never touched, flag forced high while driving
    next_pef_a_n = ~PORT_A_BUS_OE_N
                 | ~(|dcfb_pkg::par_fail(a_s.bus, m_s.odd));   // R9
    next_pef_b_n = ~PORT_B_BUS_OE_N
                 | ~(|(dcfb_pkg::par_fail(b_s.bus, m_s.odd) & lane_ok)); // R9
  end

  // register everything; reset gives constants, but offset loads the selected preset and the port clock delays keep tracking
  always_ff @(posedge CORE_CLK) begin
    offset  <= next_offset;
    a_clk_d <= next_a_clk_d;   // tracks through reset: no false edge after
    b_clk_d <= next_b_clk_d;
    if (RESET) begin
      armed1   <= 1'b0;
      armed2   <= 1'b0;
      wptr     <= '0;
      w_gray   <= '0;
      rg_a1    <= '0;
      rg_a2    <= '0;
      rptr     <= '0;
      r_gray   <= '0;
      wg_b1    <= '0;
      wg_b2    <= '0;
      fptr     <= '0;
      buf_wp   <= 1'b0;
      buf_rp   <= 1'b0;
      buf_cnt  <= 2'h0;
      part     <= 2'h0;
      mail1    <= '0;
      mail2    <= '0;
      mail_b_n <= 1'b1;
      mail_a_n <= 1'b1;
      a_out    <= '0;
      b_out    <= '0;
      pef_a_n  <= 1'b1;
      pef_b_n  <= 1'b1;
    end else begin
      armed1   <= next_armed1;
      armed2   <= next_armed2;
      wptr     <= next_wptr;
      w_gray   <= next_w_gray;
      rg_a1    <= next_rg_a1;
      rg_a2    <= next_rg_a2;
      rptr     <= next_rptr;
      r_gray   <= next_r_gray;
      wg_b1    <= next_wg_b1;
      wg_b2    <= next_wg_b2;
      fptr     <= next_fptr;
      buf_wp   <= next_buf_wp;
      buf_rp   <= next_buf_rp;
      buf_cnt  <= next_buf_cnt;
      part     <= next_part;
      mail1    <= next_mail1;
      mail2    <= next_mail2;
      mail_b_n <= next_mail_b_n;
      mail_a_n <= next_mail_a_n;
      a_out    <= next_a_out;
      b_out    <= next_b_out;
      pef_a_n  <= next_pef_a_n;
      pef_b_n  <= next_pef_b_n;
    end
  end

  // queue and buffer storage carry no reset
  always_ff @(posedge CORE_CLK) begin
    if (wr_fifo) mem[wptr[PW-2:0]] <= a_s.bus;                 // R1
    if (push) buf_q[buf_wp] <= mem[fptr[PW-2:0]];
  end

  AST_FULL_RESET: assert property (@(posedge CORE_CLK) // R18
    RESET |=> !FULL_FLAG_N) else $error("full flag high after reset");
  AST_EMPTY_RESET: assert property (@(posedge CORE_CLK) // R19
    RESET |=> !EMPTY_FLAG_N) else $error("empty flag high after reset");
  AST_A_RELEASE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $past(PORT_A_SELECT_N, 2) |-> PORT_A_BUS_OE_N)
    else $error("port a driven unselected"); // R16
  AST_MAIL_B_SET: assert property (@(posedge CORE_CLK) disable iff (RESET)
    wr_mail1 |=> !MAIL_TO_B_FLAG_N && mail1 == $past(a_s.bus))
    else $error("mail to b not stored"); // R21
  AST_MAIL_A_SET: assert property (@(posedge CORE_CLK) disable iff (RESET)
    wr_mail2 |=> !MAIL_TO_A_FLAG_N ##1 MAIL_TO_A_FLAG_N == $past(rd_mail2))
    else $error("mail to a flag wrong"); // R8
  AST_NO_OVERFLOW: assert property (@(posedge CORE_CLK) disable iff (RESET)
    wr_fifo |-> wptr - rptr < DEPTH_P) else $error("queue overrun"); // R1
  AST_AE_LEVEL: assert property (@(posedge CORE_CLK) disable iff (RESET)
    7'(cnt_b) <= offset |-> !ALMOST_EMPTY_N) else $error("ae wrong"); // R13
  AST_AF_LEVEL: assert property (@(posedge CORE_CLK) disable iff (RESET)
    7'(DEPTH_P - cnt_a) <= offset |-> !ALMOST_FULL_N)
    else $error("af wrong"); // R14
  AST_PART_POP: assert property (@(posedge CORE_CLK) disable iff (RESET)
    rd_fifo && b_s.size == dcfb_pkg::SIZE_BYTE && part == 2'h0
    |=> rptr == $past(rptr) && part == 2'h1) else $error("byte popped early"); // R22
  AST_EMPTY_RISE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(EMPTY_FLAG_N) |-> $past(b_edge))
    else $error("empty rose off edge"); // R12
endmodule : dcfb_top

// ===== dcfb_pkg.sv
/*
  Shared constants, pin bundles and helper functions for the bus-matching
  queue, plus the two-flop input synchroniser used on every pin group.
  Assumes one core clock that is fast enough to oversample both port clocks.
*/
`timescale 1ns/1ns
package dcfb_pkg;
  localparam int FIFO_DEPTH  = 64;            // stored words
  localparam int WORD_W      = 36;            // long word width
  localparam int LANE_W      = 9;             // byte lane incl. parity bit
  localparam int LANES       = 4;             // byte lanes per long word
  localparam int HALF_W      = 18;            // word (half) width
  localparam int PAR_BIT     = 8;             // parity bit inside a lane
  localparam int SYNC_STAGES = 2;             // flops before any logic
  // port b size pins: the all-ones code selects the mailbox
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h2;
  localparam logic [1:0] SIZE_MAIL = 2'h3;
  // byte-order swap modes
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_REV  = 2'h1;    // 3-2-1-0 reversed
  localparam logic [1:0] SWAP_HALF = 2'h2;    // halves exchanged
  localparam logic [1:0] SWAP_PAIR = 2'h3;    // bytes swapped per half
  localparam logic [1:0] PART_LAST_WORD = 2'h1;
  localparam logic [1:0] PART_LAST_BYTE = 2'h3;
  // four offset presets chosen by the preset select pins
  localparam logic [6:0] OFFSET_P0 = 7'h10;
  localparam logic [6:0] OFFSET_P1 = 7'h0C;
  localparam logic [6:0] OFFSET_P2 = 7'h08;
  localparam logic [6:0] OFFSET_P3 = 7'h04;

  typedef logic [WORD_W-1:0] dcfb_word_t;

  typedef struct packed {        // port a pin group
    logic       clk;
    logic       sel_n;
    logic       go;
    logic       write;
    logic       mbx;
    logic       pgen;
    dcfb_word_t bus;
  } dcfb_a_pins_t;

  typedef struct packed {        // port b pin group
    logic       clk;
    logic       sel_n;
    logic       go;
    logic       write;
    logic [1:0] size;
    logic [1:0] swap;
    logic       pgen;
    logic       endian;
    dcfb_word_t bus;
  } dcfb_b_pins_t;

  typedef struct packed {        // shared static pins
    logic       odd;
    logic [1:0] preset;
  } dcfb_misc_t;

  // rewrite the parity bit of each lane
  function automatic dcfb_word_t par_gen(input dcfb_word_t w,
                                         input logic odd);
    dcfb_word_t r;
    r = w;
    for (int i = 0; i < LANES; i++) begin
      r[i*LANE_W+PAR_BIT] = (^w[i*LANE_W +: PAR_BIT]) ^ odd;
    end
    return r;
  endfunction : par_gen

  // one bit per lane: high when that lane fails parity
  function automatic logic [LANES-1:0] par_fail(input dcfb_word_t w,
                                               input logic odd);
    logic [LANES-1:0] f;
    f = '0;
    for (int i = 0; i < LANES; i++) begin
      f[i] = (^w[i*LANE_W +: LANE_W]) != odd;
    end
    return f;
  endfunction : par_fail

  function automatic dcfb_word_t swap(input dcfb_word_t w,
                                      input logic [1:0] m);
    case (m)
      SWAP_REV:  return {w[8:0], w[17:9], w[26:18], w[35:27]};
      SWAP_HALF: return {w[17:0], w[35:18]};
      SWAP_PAIR: return {w[26:18], w[35:27], w[8:0], w[17:9]};
      default:   return w;
    endcase
  endfunction : swap
endpackage : dcfb_pkg

// two-flop synchroniser for a bundle of pins; only q is read outside
module dcfb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;   // first stage, read by q only
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // next values: clear on reset, else shift
  always_comb begin
    next_meta = reset ? '0 : d;
    next_q    = reset ? '0 : meta;
  end

  // register both stages
  always_ff @(posedge clk) begin
    meta <= next_meta;
    q    <= next_q;
  end
endmodule : dcfb_sync

// ===== dcfb_far.sv
/*
  Far-side model of one port: a free-running port clock and the level
  seen on the shared data wire. Assumes the bench drives host data and
  host enable; the device drives when its enable is low.
*/
`timescale 1ns/1ns
module dcfb_far #(
  parameter int HALF  = 200,          // half period of port clock, ns
  parameter int PHASE = 10            // start offset, ns
) (
  output logic              port_clk,
  input  wire logic [35:0]  dev_out,
  input  wire logic         dev_oe_n,
  input  wire logic [35:0]  host_out,
  input  wire logic         host_en,
  output logic      [35:0]  wire_lvl
);
  logic [35:0] last = 36'h0;          // level last driven on the wire
  // clock never stops, even outside transfers
  initial begin
    port_clk = 1'b0;
    #(PHASE);
    forever #(HALF) port_clk = ~port_clk;
  end
  // remember the driven level
  always @(dev_out, dev_oe_n, host_out, host_en)
    if (!dev_oe_n) last = dev_out;
    else if (host_en) last = host_out;
  // no pull on the wire: released shows the inverse, never a stale copy
  assign wire_lvl = !dev_oe_n ? dev_out : host_en ? host_out : ~last;
endmodule : dcfb_far

// ===== dcfb_top_test.sv
/*
  Self-checking bench: queue model compared at every port b queue read.
  Assumes dcfb_far makes both port clocks and resolves both buses.
*/
`timescale 1ns/1ns
module dcfb_top_test;
  localparam int DEP = 8;             // short depth reaches full quickly
  localparam int OFS = int'(dcfb_pkg::OFFSET_P3); // preset code 3
  logic        CORE_CLK, RESET, a_clk, b_clk;
  logic        a_sel_n, a_go, a_wr, a_mbx, a_pg, a_den;
  logic        b_sel_n, b_go, b_wr, b_pg, b_end, b_den;
  logic [1:0]  b_sz, b_sw, pre;
  logic [35:0] a_drv, b_drv, a_in, b_in, a_out, b_out, d, w, x, m;
  logic        a_oe_n, b_oe_n, ff_n, af_n, ef_n, ae_n;
  logic        mb_n, ma_n, pa_n, pb_n;
  int          n_mismatch, num_checks, seed, sz, sw, e, pg, n, wd;
  logic [35:0] q[$];                  // model of queue contents

  dcfb_top #(.DEPTH(DEP)) dcfb_top_inst (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .PORT_A_CLOCK(a_clk),
    .PORT_A_SELECT_N(a_sel_n), .PORT_A_GO(a_go), .PORT_A_WRITE(a_wr),
    .PORT_A_MAILBOX(a_mbx), .PORT_A_PARITY_GEN(a_pg),
    .PORT_A_BUS_IN(a_in), .PORT_A_BUS_OUT(a_out),
    .PORT_A_BUS_OE_N(a_oe_n), .PORT_B_CLOCK(b_clk),
    .PORT_B_SELECT_N(b_sel_n), .PORT_B_GO(b_go), .PORT_B_WRITE(b_wr),
    .PORT_B_SIZE(b_sz), .PORT_B_SWAP(b_sw), .PORT_B_PARITY_GEN(b_pg),
    .ENDIAN_SELECT(b_end), .PORT_B_BUS_IN(b_in), .PORT_B_BUS_OUT(b_out),
    .PORT_B_BUS_OE_N(b_oe_n), .ODD_PARITY(1'b1),
    .OFFSET_PRESET_SEL(pre), .FULL_FLAG_N(ff_n), .ALMOST_FULL_N(af_n),
    .EMPTY_FLAG_N(ef_n), .ALMOST_EMPTY_N(ae_n),
    .MAIL_TO_B_FLAG_N(mb_n), .MAIL_TO_A_FLAG_N(ma_n),
    .PARITY_ERR_A_N(pa_n), .PARITY_ERR_B_N(pb_n));
  // port clocks unrelated in phase and rate
  dcfb_far #(.HALF(200), .PHASE(10)) dcfb_far_a (.port_clk(a_clk),
    .dev_out(a_out), .dev_oe_n(a_oe_n), .host_out(a_drv),
    .host_en(a_den), .wire_lvl(a_in));
  dcfb_far #(.HALF(250), .PHASE(70)) dcfb_far_b (.port_clk(b_clk),
    .dev_out(b_out), .dev_oe_n(b_oe_n), .host_out(b_drv),
    .host_en(b_den), .wire_lvl(b_in));

  initial CORE_CLK = 1'b0;
  always #25 CORE_CLK = ~CORE_CLK;    // 20 MHz core clock

  // expected byte order after a swap mode
  function automatic logic [35:0] swp(input logic [35:0] v, input int c);
    case (c)
      1: return {v[8:0], v[17:9], v[26:18], v[35:27]};
      2: return {v[17:0], v[35:18]};
      3: return {v[26:18], v[35:27], v[8:0], v[17:9]};
      default: return v;
    endcase
  endfunction : swp
  // high when any lane fails odd parity
  function automatic logic bad(input logic [35:0] v);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 4; i++) b |= ~^v[i*9 +: 9];
    return b;
  endfunction : bad
  task automatic chk_w(input string nm, input logic [35:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_w
  task automatic chk_f(input string nm, input logic ex, got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_f
  // one port a access; pins held from clock fall to the next fall
  task automatic a_op(input logic wr, mx, input logic [35:0] v);
    @(negedge a_clk);
    @(negedge CORE_CLK);
    a_sel_n = 1'b0;
    {a_go, a_wr, a_mbx, a_den, a_drv} = {1'b1, wr, mx, wr, v};
    @(negedge a_clk);
    @(negedge CORE_CLK);
    if (wr) chk_f("par_a", ~bad(v), pa_n);
    else chk_f("oe_a", 1'b0, a_oe_n);
    {a_sel_n, a_go, a_den} = 3'h4;
  endtask : a_op
  // one port b access with size, swap, endian and parity options
  task automatic b_op(input logic wr, input int s, c, en, pgn,
                      input logic [35:0] v);
    @(negedge b_clk);
    @(negedge CORE_CLK);
    b_sel_n = 1'b0;
    {b_go, b_wr, b_den, b_end, b_pg} = {1'b1, wr, wr, en[0], pgn[0]};
    {b_sz, b_sw, b_drv} = {s[1:0], c[1:0], v};
    @(negedge b_clk);
    @(negedge CORE_CLK);
    if (wr) chk_f("par_b", ~bad(v), pb_n);
    else chk_f("oe_b", 1'b0, b_oe_n);
    {b_sel_n, b_go, b_den} = 3'h4;
  endtask : b_op
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // watchdog: the whole run needs well under a millisecond
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    seed = 32'h63712cf8;
    {a_sel_n, b_sel_n, RESET} = 3'h7;
    {a_go, a_wr, a_mbx, a_pg, a_den, a_drv} = 41'h0;
    {b_go, b_wr, b_pg, b_end, b_den, b_drv} = 41'h0;
    {b_sz, b_sw, pre} = 6'h03;        // offset preset code 3
    repeat (4) @(negedge CORE_CLK);
    chk_f("ff", 1'b0, ff_n);
    chk_f("ef", 1'b0, ef_n);
    chk_f("mb", 1'b1, mb_n);
    RESET = 1'b0;
    repeat (3) @(negedge a_clk);
    chk_f("ff", 1'b1, ff_n);
    // fill one past full: the last word must be dropped
    for (int i = 0; i <= DEP; i++) begin
      d[31:0] = $random(seed);
      d[35:32] = 4'($random(seed));
      a_op(1'b1, 1'b0, d);
      if (i < DEP) q.push_back(d);
      chk_f("ff", q.size() < DEP, ff_n);
      chk_f("af", DEP - q.size() > OFS, af_n);
    end
    repeat (3) @(negedge b_clk);
    // drain with every size, swap mode and both endian levels
    for (int j = 0; j < DEP; j++) begin
      sz = (j + 2) % 3;
      sw = j % 4;
      e = (j >> 1) & 1;
      pg = (sz == 0);
      w = swp(q.pop_front(), sw);
      for (int i = 0; i < 4 && pg; i++) w[i*9+8] = ~^w[i*9 +: 8];
      n = 1 << sz;
      wd = 36 / n;
      for (int k = 0; k < n; k++) begin
        b_op(1'b0, sz, sw, e, pg, 36'h0);
        x = w >> (wd * (e ? k : n - 1 - k));
        m = 36'hF_FFFF_FFFF >> (36 - wd);
        if (!e) x = x << (36 - wd);
        if (!e) m = m << (36 - wd);
        chk_w("b_data", x & m, b_out & m);
      end
      chk_f("ae", q.size() > OFS, ae_n);
      chk_f("ef", q.size() > 0, ef_n);
    end
    // read from empty queue leaves the output alone
    b_op(1'b0, 0, 3, 1, 1, 36'h0);
    chk_w("b_hold", w, b_out);
    // mailboxes both ways; second mail refused while unread
    a_op(1'b1, 1'b1, d);
    chk_f("mb", 1'b0, mb_n);
    a_op(1'b1, 1'b1, ~d);
    b_op(1'b0, 3, 0, 0, 0, 36'h0);
    chk_w("mail_b", d, b_out);
    chk_f("mb", 1'b1, mb_n);
    b_op(1'b1, 3, 0, 0, 0, ~d);
    chk_f("ma", 1'b0, ma_n);
    a_op(1'b0, 1'b1, 36'h0);
    chk_w("mail_a", ~d, a_out);
    chk_f("ma", 1'b1, ma_n);
    @(negedge a_clk);
    chk_f("oe_a", 1'b1, a_oe_n);
    end_of_test();
  end
endmodule : dcfb_top_test
